// ### rtl/mpbi_defines.svh
// Constants of the microcontroller parallel bus interface
`ifndef MPBI_DEFINES_SVH
`define MPBI_DEFINES_SVH

// Synchroniser depth for every pin input
`define MPBI_SYNC_STAGES 2
// Static configuration pin field positions
`define MPBI_CFG_WIDTH 7
`define MPBI_CFG_MODE_LSB 0
`define MPBI_CFG_MODE_MSB 1
`define MPBI_CFG_WR_RW_BIT 2
`define MPBI_CFG_RD_LSB 3
`define MPBI_CFG_RD_MSB 4
`define MPBI_CFG_STRB_LOW_BIT 5
`define MPBI_CFG_FETCH_BIT 6
// Cycles after reset release before the configuration is sampled
`define MPBI_CFG_WAIT 2'h2
// Reset values
`define MPBI_RST_BYTE 8'h00
`define MPBI_RST_ADDR 16'h0000
`define MPBI_RST_CNT 2'h0

`endif

// ### rtl/mpbi_pkg.sv
// Types of the microcontroller parallel bus interface
package mpbi_pkg;

    // Port usage chosen to match the host bus
    typedef enum logic [1:0] {
        MPBI_MODE_MUX    = 2'b00,
        MPBI_MODE_NONMUX = 2'b01,
        MPBI_MODE_PAGE   = 2'b10,
        MPBI_MODE_BURST  = 2'b11
    } mpbi_bus_mode_t;

    // Meaning of the read control input
    typedef enum logic [1:0] {
        MPBI_RD_STROBE = 2'b00,
        MPBI_RD_ECLK   = 2'b01,
        MPBI_RD_DS     = 2'b10,
        MPBI_RD_FETCH  = 2'b11
    } mpbi_rd_style_t;

    // Bus cycle phase
    typedef enum logic [1:0] {
        MPBI_ST_IDLE  = 2'b00,
        MPBI_ST_ADDR  = 2'b01,
        MPBI_ST_CYCLE = 2'b10
    } mpbi_state_t;

endpackage

// ### rtl/mpbi_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module mpbi_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // First stage is read only by the second stage
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule

// ### rtl/mpbi_top.sv
// Host bus interface: address latch, control decode and read data drive
//
// Summary of operation
// - Latch address on address strobe, either style.
// - Drive data only on read with block selected.
// - Pass both address ports to decode logic.
// - Write input: write strobe or read/write direction.
// - Read input: read strobe, E clock, data strobe.
// - Write and read inputs feed the logic.
// - Code select strobe, else a generic input.
// - Reset returns ports and configuration to defaults.
`timescale 1ns/10ps
`include "mpbi_defines.svh"
module mpbi_top import mpbi_pkg::*; (
    input  wire logic                       ref_clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic [7:0]                 lower_addr_data_port_i,
    input  wire logic [7:0]                 upper_addr_data_port_i,
    input  wire logic                       addr_latch_i,
    input  wire logic                       write_ctrl_input_i,
    input  wire logic                       read_ctrl_input_i,
    input  wire logic                       code_select_input_i,
    input  wire logic [`MPBI_CFG_WIDTH-1:0] cfg_i,
    input  wire logic                       blk_sel_i,
    input  wire logic [15:0]                rd_data_i,
    output logic      [7:0]                 lower_addr_data_port_o,
    output logic                            lower_addr_data_port_oe_o,
    output logic      [7:0]                 upper_addr_data_port_o,
    output logic                            upper_addr_data_port_oe_o,
    output logic      [15:0]                addr_o,
    output logic                            addr_valid_o,
    output logic                            rd_active_o,
    output logic                            wr_active_o,
    output logic                            pld_write_ctrl_o,
    output logic                            pld_read_ctrl_o,
    output logic                            pld_code_select_o,
    output logic                            cfg_done_o
);
    localparam int SW = 20 + `MPBI_CFG_WIDTH;

    logic [SW-1:0]               pins_sync;
    logic [7:0]                  s_lo;
    logic [7:0]                  s_hi;
    logic                        s_strobe;
    logic                        s_c0;
    logic                        s_c1;
    logic                        s_c2;
    logic [`MPBI_CFG_WIDTH-1:0]  s_cfg;

    // All pin inputs pass two flip-flops first
    mpbi_sync #(.WIDTH(SW)) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   ({cfg_i, code_select_input_i, read_ctrl_input_i, write_ctrl_input_i,
                     addr_latch_i, upper_addr_data_port_i, lower_addr_data_port_i}),
        .sync_o    (pins_sync)
    );

    assign {s_cfg, s_c2, s_c1, s_c0, s_strobe, s_hi, s_lo} = pins_sync;

    // Static configuration state
    mpbi_bus_mode_t  mode_reg,      mode_next;
    mpbi_rd_style_t  rd_style_reg,  rd_style_next;
    logic            wr_rw_reg,     wr_rw_next;
    logic            strb_low_reg,  strb_low_next;
    logic            fetch_en_reg,  fetch_en_next;
    logic            cfg_done_reg,  cfg_done_next;
    logic [1:0]      cfg_cnt_reg,   cfg_cnt_next;

    // Sample the configuration once, after the synchroniser has filled
    always_comb begin
        mode_next     = mode_reg;
        rd_style_next = rd_style_reg;
        wr_rw_next    = wr_rw_reg;
        strb_low_next = strb_low_reg;
        fetch_en_next = fetch_en_reg;
        cfg_done_next = cfg_done_reg;
        cfg_cnt_next  = cfg_cnt_reg;
        if (!cfg_done_reg) begin
            if (cfg_cnt_reg == `MPBI_CFG_WAIT) begin
                mode_next     = mpbi_bus_mode_t'(s_cfg[`MPBI_CFG_MODE_MSB:`MPBI_CFG_MODE_LSB]);
                rd_style_next = mpbi_rd_style_t'(s_cfg[`MPBI_CFG_RD_MSB:`MPBI_CFG_RD_LSB]);
                wr_rw_next    = s_cfg[`MPBI_CFG_WR_RW_BIT];
                strb_low_next = s_cfg[`MPBI_CFG_STRB_LOW_BIT];
                fetch_en_next = s_cfg[`MPBI_CFG_FETCH_BIT];
                cfg_done_next = 1'b1;
            end else begin
                cfg_cnt_next = cfg_cnt_reg + 2'h1;
            end
        end
    end

    // Configuration registers, cleared by reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg     <= MPBI_MODE_MUX;
            rd_style_reg <= MPBI_RD_STROBE;
            wr_rw_reg    <= 1'b0;
            strb_low_reg <= 1'b0;
            fetch_en_reg <= 1'b0;
            cfg_done_reg <= 1'b0;
            cfg_cnt_reg  <= `MPBI_RST_CNT;
        end else begin
            mode_reg     <= mode_next;
            rd_style_reg <= rd_style_next;
            wr_rw_reg    <= wr_rw_next;
            strb_low_reg <= strb_low_next;
            fetch_en_reg <= fetch_en_next;
            cfg_done_reg <= cfg_done_next;
            cfg_cnt_reg  <= cfg_cnt_next;
        end
    end

    // Decoded strobes from the control inputs
    logic strobe_act;
    logic rd_act;
    logic wr_act;
    logic nonmux;

    always_comb begin
        strobe_act = cfg_done_reg & (s_strobe ^ strb_low_reg);
        nonmux     = (mode_reg == MPBI_MODE_NONMUX);
        case (rd_style_reg)
            MPBI_RD_STROBE: rd_act = ~s_c1;
            MPBI_RD_FETCH:  rd_act = ~s_c1;
            MPBI_RD_ECLK:   rd_act = s_c1 & s_c0;
            MPBI_RD_DS:     rd_act = ~s_c1 & s_c0;
            default:        rd_act = 1'b0;
        endcase
        if (fetch_en_reg) begin
            rd_act = rd_act | ~s_c2;
        end
        if (!wr_rw_reg) begin
            wr_act = ~s_c0;
        end else if (rd_style_reg == MPBI_RD_ECLK) begin
            wr_act = ~s_c0 & s_c1;
        end else begin
            wr_act = ~s_c0 & ~s_c1;
        end
        rd_act = rd_act & cfg_done_reg;
        wr_act = wr_act & cfg_done_reg;
    end

    // Bus cycle and data drive state
    mpbi_state_t state_reg,  state_next;
    logic [15:0] addr_reg,   addr_next;
    logic        valid_reg,  valid_next;
    logic        rd_reg,     rd_next;
    logic        wr_reg,     wr_next;
    logic [2:0]  ctrl_reg,   ctrl_next;
    logic [7:0]  lo_reg,     lo_next;
    logic        lo_oe_reg,  lo_oe_next;
    logic [7:0]  hi_reg,     hi_next;
    logic        hi_oe_reg,  hi_oe_next;
    logic        rd_ok;

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        case (state_reg)
            MPBI_ST_IDLE: begin
                if (strobe_act && !nonmux) begin
                    state_next = MPBI_ST_ADDR;
                end
            end
            MPBI_ST_ADDR: begin
                if (!strobe_act) begin
                    state_next = MPBI_ST_CYCLE;
                end
            end
            MPBI_ST_CYCLE: begin
                if (strobe_act) begin
                    state_next = MPBI_ST_ADDR;
                end
            end
            default: state_next = MPBI_ST_IDLE;
        endcase
        // Address into decode logic: latched while the strobe is active; always follows pins in non-multiplexed mode, lower byte in page mode
        if (nonmux) begin
            addr_next = {s_hi, s_lo};
        end else if (strobe_act) begin
            addr_next = {s_hi, s_lo};
        end
        if (mode_reg == MPBI_MODE_PAGE) begin
            addr_next[7:0] = s_lo;
        end
        valid_next = cfg_done_reg & (nonmux | (state_next == MPBI_ST_CYCLE));
        rd_next    = rd_act;
        wr_next    = wr_act;
        ctrl_next  = {s_c2, s_c1, s_c0};
        // Drive only in the data phase of a selected read
        rd_ok      = rd_act & blk_sel_i & ~strobe_act & ~nonmux;
        lo_oe_next = rd_ok & ((mode_reg == MPBI_MODE_MUX) | (mode_reg == MPBI_MODE_BURST));
        hi_oe_next = rd_ok & ((mode_reg == MPBI_MODE_PAGE) | (mode_reg == MPBI_MODE_BURST));
        lo_next    = lo_oe_next ? rd_data_i[7:0] : `MPBI_RST_BYTE;
        if (!hi_oe_next) begin
            hi_next = `MPBI_RST_BYTE;
        end else if (mode_reg == MPBI_MODE_BURST) begin
            hi_next = rd_data_i[15:8];
        end else begin
            hi_next = rd_data_i[7:0];
        end
    end

    // Bus cycle registers; ports released in reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= MPBI_ST_IDLE;
            addr_reg  <= `MPBI_RST_ADDR;
            valid_reg <= 1'b0;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            ctrl_reg  <= 3'h0;
            lo_reg    <= `MPBI_RST_BYTE;
            lo_oe_reg <= 1'b0;
            hi_reg    <= `MPBI_RST_BYTE;
            hi_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            valid_reg <= valid_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            ctrl_reg  <= ctrl_next;
            lo_reg    <= lo_next;
            lo_oe_reg <= lo_oe_next;
            hi_reg    <= hi_next;
            hi_oe_reg <= hi_oe_next;
        end
    end

    // Outputs straight from flip-flops
    assign lower_addr_data_port_o    = lo_reg;
    assign lower_addr_data_port_oe_o = lo_oe_reg;
    assign upper_addr_data_port_o    = hi_reg;
    assign upper_addr_data_port_oe_o = hi_oe_reg;
    assign addr_o                    = addr_reg;
    assign addr_valid_o              = valid_reg;
    assign rd_active_o               = rd_reg;
    assign wr_active_o               = wr_reg;
    assign pld_write_ctrl_o          = ctrl_reg[0];
    assign pld_read_ctrl_o           = ctrl_reg[1];
    assign pld_code_select_o         = ctrl_reg[2];
    assign cfg_done_o                = cfg_done_reg;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence seq_addr_phase;
        strobe_act && !nonmux ##1 !strobe_act;
    endsequence

    a_addr_phase_end: assert property (seq_addr_phase |=> state_reg == MPBI_ST_CYCLE)
        else $error("address phase did not end in data cycle");
    a_addr_capture: assert property (strobe_act && mode_reg != MPBI_MODE_PAGE
        |=> addr_o == $past({s_hi, s_lo}))
        else $error("address not captured on strobe");
    a_addr_hold: assert property (cfg_done_reg && mode_reg == MPBI_MODE_MUX && !strobe_act
        |=> $stable(addr_o))
        else $error("latched address changed without strobe");
    a_drive_needs_sel: assert property (lower_addr_data_port_oe_o || upper_addr_data_port_oe_o
        |-> $past(blk_sel_i) && $past(rd_act) && !$past(strobe_act))
        else $error("data driven without selected read");
    a_nonmux_quiet: assert property (nonmux && cfg_done_reg
        |=> !lower_addr_data_port_oe_o && !upper_addr_data_port_oe_o)
        else $error("ports driven in non-multiplexed mode");
    a_ctrl_pass: assert property (##1 pld_write_ctrl_o == $past(s_c0)
        && pld_read_ctrl_o == $past(s_c1) && pld_code_select_o == $past(s_c2))
        else $error("control inputs not passed to logic");
    a_write_strobe: assert property (cfg_done_reg && !wr_rw_reg && !s_c0 |=> wr_active_o)
        else $error("write strobe not decoded");
    a_read_strobe: assert property (cfg_done_reg && rd_style_reg == MPBI_RD_STROBE && !s_c1
        |=> rd_active_o)
        else $error("read strobe not decoded");
    a_cfg_frozen: assert property (cfg_done_reg |=> $stable(mode_reg) && $stable(rd_style_reg)
        && $stable(wr_rw_reg))
        else $error("configuration changed after sampling");
    a_reset_quiet: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !arst_n_i |-> !lower_addr_data_port_oe_o && !upper_addr_data_port_oe_o
        && !cfg_done_o)
        else $error("ports not released in reset");
endmodule

// ### testbench/mpbi_host_model.sv
// Host microcontroller model that drives the parallel bus pins
`timescale 1ns/10ps
`include "mpbi_defines.svh"
module mpbi_host_model (
    input  wire logic [`MPBI_CFG_WIDTH-1:0] cfg_i,
    output logic      [7:0]                 lower_o,
    output logic      [7:0]                 upper_o,
    output logic                            latch_o,
    output logic                            write_ctrl_o,
    output logic                            read_ctrl_o,
    output logic                            code_select_o
);
    // Pins start quiet until the bench configures the host
    initial begin
        lower_o       = 8'h00;
        upper_o       = 8'h00;
        latch_o       = 1'b0;
        write_ctrl_o  = 1'b1;
        read_ctrl_o   = 1'b1;
        code_select_o = 1'b1;
    end

    // Inactive control levels; an E clock idles low, the address strobe at its configured inactive level, every other strobe high
    task automatic idle();
        latch_o       = cfg_i[5];
        write_ctrl_o  = 1'b1;
        read_ctrl_o   = (cfg_i[4:3] != 2'h1);
        code_select_o = 1'b1;
    endtask

    // Address phase: full address on both ports with the strobe active
    task automatic addr_phase(input logic [15:0] addr);
        lower_o = addr[7:0];
        upper_o = addr[15:8];
        latch_o = ~cfg_i[5];
    endtask

    // Data phase: strobe off, multiplexed lines released and toggled, controls applied
    task automatic data_phase(input logic w, input logic r, input logic s);
        latch_o = cfg_i[5];
        if (cfg_i[1:0] == 2'h0 || cfg_i[1:0] == 2'h3) begin
            lower_o = ~lower_o;
        end
        if (cfg_i[1:0] == 2'h2 || cfg_i[1:0] == 2'h3) begin
            upper_o = ~upper_o;
        end
        write_ctrl_o  = w;
        read_ctrl_o   = r;
        code_select_o = s;
    endtask
endmodule

// ### testbench/mpbi_top_tb.sv
// Self-checking bench for the host bus interface
`timescale 1ns/10ps
`include "mpbi_defines.svh"
module mpbi_top_tb import mpbi_pkg::*;;
    logic                       ref_clk_i;
    logic                       arst_n_i;
    logic                       blk_sel_i;
    logic [15:0]                rd_data_i;
    logic [`MPBI_CFG_WIDTH-1:0] cfg_i;
    logic [7:0]                 h_lower, h_upper, lo_o, up_o, lo_pin, up_pin;
    logic                       h_latch, h_wr, h_rd, h_cs, lo_oe, up_oe;
    logic [15:0]                addr_o;
    logic                       addr_valid, rd_act, wr_act, p_wr, p_rd, p_cs, cfg_done;
    int                         err_total = 0;
    int                         checks = 0;
    integer                     seed = 32'hFF2BF143;
    logic [6:0]                 cfg_tab [6] = '{7'h00, 7'h0D, 7'h36, 7'h5B, 7'h20, 7'h44};

    // Pin level resolved from the interface's enables; the host drives the pins otherwise
    assign lo_pin = lo_oe ? lo_o : h_lower;
    assign up_pin = up_oe ? up_o : h_upper;

    // Clock at 40 MHz
    initial ref_clk_i = 1'b0;
    always #12.5 ref_clk_i = ~ref_clk_i;

    mpbi_host_model host (
        .cfg_i         (cfg_i),
        .lower_o       (h_lower),
        .upper_o       (h_upper),
        .latch_o       (h_latch),
        .write_ctrl_o  (h_wr),
        .read_ctrl_o   (h_rd),
        .code_select_o (h_cs)
    );

    mpbi_top dut (
        .ref_clk_i                 (ref_clk_i),
        .arst_n_i                  (arst_n_i),
        .lower_addr_data_port_i    (lo_pin),
        .upper_addr_data_port_i    (up_pin),
        .addr_latch_i              (h_latch),
        .write_ctrl_input_i        (h_wr),
        .read_ctrl_input_i         (h_rd),
        .code_select_input_i       (h_cs),
        .cfg_i                     (cfg_i),
        .blk_sel_i                 (blk_sel_i),
        .rd_data_i                 (rd_data_i),
        .lower_addr_data_port_o    (lo_o),
        .lower_addr_data_port_oe_o (lo_oe),
        .upper_addr_data_port_o    (up_o),
        .upper_addr_data_port_oe_o (up_oe),
        .addr_o                    (addr_o),
        .addr_valid_o              (addr_valid),
        .rd_active_o               (rd_act),
        .wr_active_o               (wr_act),
        .pld_write_ctrl_o          (p_wr),
        .pld_read_ctrl_o           (p_rd),
        .pld_code_select_o         (p_cs),
        .cfg_done_o                (cfg_done)
    );

    // Compare one result and count it
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Expected {read, write} activity for a configuration and control levels
    function automatic logic [1:0] exp_rw(input logic [6:0] c, input logic w, input logic r,
                                          input logic s);
        logic rd;
        logic wr;
        case (c[4:3])
            2'h1: begin rd = r & w;   wr = r & ~w;  end
            2'h2: begin rd = ~r & w;  wr = ~r & ~w; end
            default: begin rd = ~r;   wr = ~r & ~w; end
        endcase
        // A plain write strobe ignores the read input
        if (!c[2]) begin
            wr = ~w;
        end
        rd = rd | (c[6] & ~s);
        return {rd, wr};
    endfunction

    // Reset with a new static configuration, then wait for it to be taken
    task automatic do_reset(input logic [6:0] c);
        int n;
        arst_n_i  = 1'b0;
        cfg_i     = c;
        blk_sel_i = 1'b0;
        host.idle();
        repeat (3) @(negedge ref_clk_i);
        chk("reset_outs", 17'h00000, {lo_oe, up_oe, addr_valid, rd_act, wr_act, cfg_done,
                                      p_wr, p_rd, p_cs, lo_o});
        chk("reset_addr", 17'h00000, {1'b0, addr_o});
        arst_n_i = 1'b1;
        for (n = 0; n < 20 && cfg_done !== 1'b1; n++) @(negedge ref_clk_i);
        chk("cfg_done", 17'h00001, {16'h0000, cfg_done});
    endtask

    // One full bus cycle: address phase, data phase, release
    task automatic bus_cycle(input int i);
        logic [15:0] a;
        logic [15:0] d;
        logic [1:0]  e;
        logic        w;
        logic        r;
        logic        s;
        logic        lo_drv;
        logic        up_drv;
        logic [1:0]  m;
        w = i[0];
        r = i[1];
        s = i[2];
        m = cfg_i[1:0];
        a = (i == 0) ? 16'hFFFF : 16'($random(seed));
        d = 16'($random(seed));
        host.addr_phase(a);
        blk_sel_i = (i == 0) ? 1'b1 : 1'($random(seed));
        rd_data_i = d;
        repeat (6) @(negedge ref_clk_i);
        chk("addr_phase", {16'h0000, m == MPBI_MODE_NONMUX},
            {14'h0000, lo_oe, up_oe, addr_valid});
        host.data_phase(w, r, s);
        repeat (6) @(negedge ref_clk_i);
        e = exp_rw(cfg_i, w, r, s);
        lo_drv = e[1] & blk_sel_i & (m == MPBI_MODE_MUX || m == MPBI_MODE_BURST);
        up_drv = e[1] & blk_sel_i & (m == MPBI_MODE_PAGE || m == MPBI_MODE_BURST);
        chk("addr", {1'b0, a}, {1'b0, addr_o});
        chk("addr_valid", 17'h00001, {16'h0000, addr_valid});
        chk("rd_active", {16'h0000, e[1]}, {16'h0000, rd_act});
        chk("wr_active", {16'h0000, e[0]}, {16'h0000, wr_act});
        chk("pld_ctrl", {14'h0000, w, r, s}, {14'h0000, p_wr, p_rd, p_cs});
        chk("lower_port", {8'h00, lo_drv, lo_drv ? d[7:0] : 8'h00}, {8'h00, lo_oe, lo_o});
        chk("upper_port", {8'h00, up_drv, up_drv ? (m == MPBI_MODE_BURST ? d[15:8] : d[7:0])
                           : 8'h00}, {8'h00, up_oe, up_o});
        host.idle();
        repeat (5) @(negedge ref_clk_i);
        chk("released", 17'h00000, {13'h0000, lo_oe, up_oe, rd_act, wr_act});
    endtask

    // Main sequence: the six table configurations, every control combination
    initial begin
        blk_sel_i = 1'b0;
        rd_data_i = 16'h0000;
        cfg_i     = 7'h00;
        // Reset falls just after time zero so every register sees the edge
        #1 arst_n_i = 1'b0;
        for (int k = 0; k < 6; k++) begin
            do_reset(cfg_tab[k]);
            for (int i = 0; i < 8; i++) begin
                bus_cycle(i);
            end
        end
        stop_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_total++;
        stop_test();
    end
endmodule
